// file: twi_host_cfg.svh
// Constants for the two-wire serial memory host controller
`ifndef TWI_HOST_CFG_SVH
`define TWI_HOST_CFG_SVH
`define CORE_FREQ_KHZ 40000
`define SCL_FREQ_KHZ 100
`define QTR_CYCLES ((`CORE_FREQ_KHZ) / (4 * `SCL_FREQ_KHZ))
`define DEV_TYPE 4'hA
`define BYTE_MSB 7
`define ACK_BIT 4'h8
`define PAGE_BIT 8
`define PAGE_LAST 4'hF
`endif

// file: twi_host_pkg.sv
// Types shared by the serial memory host and its bit engine
package twi_host_pkg;
   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_READ_CUR = 2'b01,
      OP_READ_RAND = 2'b10
   } op_t;

   typedef struct packed {
      op_t op;
      logic [1:0] dev_sel;
      logic [8:0] addr;
      logic [3:0] len;
   } cmd_t;

   typedef enum logic [1:0] {
      E_START = 2'b00,
      E_STOP = 2'b01,
      E_WRITE = 2'b10,
      E_READ = 2'b11
   } eng_op_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_START = 4'b0001,
      S_DEV = 4'b0010,
      S_ADDR = 4'b0011,
      S_WDATA = 4'b0100,
      S_RSTART = 4'b0101,
      S_DEVR = 4'b0110,
      S_RDATA = 4'b0111,
      S_STOP = 4'b1000,
      S_PSTART = 4'b1001,
      S_PDEV = 4'b1010,
      S_PSTOP = 4'b1011
   } state_t;
endpackage : twi_host_pkg

// file: twi_bit_engine.sv
// Bit-level engine: start, stop, byte out and byte in on the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "twi_host_cfg.svh"
module twi_bit_engine #(
   parameter logic [15:0] QTR = 16'(`QTR_CYCLES)
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire twi_host_pkg::eng_op_t op_i,
   input wire logic [7:0] tx_i,
   input wire logic ack_n_i,
   output logic done_o,
   output logic acked_o,
   output logic [7:0] rx_o,
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   import twi_host_pkg::*;

   logic sync1_reg, sync2_reg;
   logic active_reg, active_next;
   eng_op_t op_reg, op_next;
   logic [1:0] ph_reg, ph_next;
   logic [3:0] bit_reg, bit_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0] sr_reg, sr_next;
   logic scl_reg, scl_next;
   logic oe_reg, oe_next;
   logic ack_reg, ack_next;
   logic ackn_reg, ackn_next;
   logic done_reg, done_next;
   logic tick;

   assign tick = (cnt_reg == QTR - 16'h1);

   always_comb begin
      active_next = active_reg;
      op_next = op_reg;
      ph_next = ph_reg;
      bit_next = bit_reg;
      cnt_next = cnt_reg;
      sr_next = sr_reg;
      scl_next = scl_reg;
      oe_next = oe_reg;
      ack_next = ack_reg;
      ackn_next = ackn_reg;
      done_next = 1'b0;
      if (!active_reg) begin
         if (req_i) begin
            active_next = 1'b1;
            op_next = op_i;
            sr_next = tx_i;
            ackn_next = ack_n_i;
            ph_next = 2'h0;
            bit_next = 4'h0;
            cnt_next = 16'h0;
         end
      end else begin
         cnt_next = tick ? 16'h0 : cnt_reg + 16'h1;
         if (tick) begin
            ph_next = ph_reg + 2'h1;
            unique case (op_reg)
               E_START: begin
                  unique case (ph_reg)
                     2'h0: oe_next = 1'b0;
                     2'h1: scl_next = 1'b1;
                     2'h2: oe_next = 1'b1;
                     2'h3: begin
                        scl_next = 1'b0;
                        active_next = 1'b0;
                        done_next = 1'b1;
                     end
                  endcase
               end
               E_STOP: begin
                  unique case (ph_reg)
                     2'h0: oe_next = 1'b1;
                     2'h1: scl_next = 1'b1;
                     2'h2: oe_next = 1'b0;
                     2'h3: begin
                        active_next = 1'b0;
                        done_next = 1'b1;
                     end
                  endcase
               end
               E_WRITE, E_READ: begin
                  unique case (ph_reg)
                     // data changes only while clock low
                     2'h0: begin
                        if (bit_reg != `ACK_BIT) begin
                           oe_next = (op_reg == E_WRITE) ? !sr_reg[`BYTE_MSB] : 1'b0;
                        end else begin
                           oe_next = (op_reg == E_READ) ? !ackn_reg : 1'b0;
                        end
                     end
                     2'h1: scl_next = 1'b1;
                     2'h2: begin
                        if (bit_reg != `ACK_BIT) begin
                           sr_next = {sr_reg[6:0], sync2_reg};
                        end else begin
                           ack_next = !sync2_reg;
                        end
                     end
                     2'h3: begin
                        scl_next = 1'b0;
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == `ACK_BIT) begin
                           active_next = 1'b0;
                           done_next = 1'b1;
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         active_reg <= 1'b0;
         op_reg <= E_STOP;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         cnt_reg <= 16'h0;
         sr_reg <= 8'h00;
         scl_reg <= 1'b1;
         oe_reg <= 1'b0;
         ack_reg <= 1'b0;
         ackn_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         sync1_reg <= sda_i;
         sync2_reg <= sync1_reg;
         active_reg <= active_next;
         op_reg <= op_next;
         ph_reg <= ph_next;
         bit_reg <= bit_next;
         cnt_reg <= cnt_next;
         sr_reg <= sr_next;
         scl_reg <= scl_next;
         oe_reg <= oe_next;
         ack_reg <= ack_next;
         ackn_reg <= ackn_next;
         done_reg <= done_next;
      end
   end

   assign done_o = done_reg;
   assign acked_o = ack_reg;
   assign rx_o = sr_reg;
   assign scl_o = scl_reg;
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_reg;

   property p_stable_high;
      @(posedge core_clk_i) disable iff (!rstn_i)
      ($changed(oe_reg) && scl_reg) |-> (op_reg == E_START || op_reg == E_STOP);
   endproperty
   a_stable_high: assert property (p_stable_high) else $error("data moved while clock high");

   property p_stop_edge;
      @(posedge core_clk_i) disable iff (!rstn_i)
      ($fell(oe_reg) && scl_reg && $past(scl_reg)) |-> (op_reg == E_STOP);
   endproperty
   a_stop_edge: assert property (p_stop_edge) else $error("data rose with clock high outside stop");
endmodule : twi_bit_engine
`default_nettype wire

// file: twi_eeprom_host.sv
// Host controller that drives a two-wire 512x8 serial memory
`timescale 1ns/1ps
`default_nettype none
`include "twi_host_cfg.svh"
module twi_eeprom_host #(
   parameter logic [15:0] QTR = 16'(`QTR_CYCLES)
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic cmd_valid_i,
   input wire twi_host_pkg::cmd_t cmd_i,
   output logic cmd_ready_o,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ready_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic done_o,
   output logic nack_o,
   input wire logic protect_i,
   output logic write_protect_o,
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   import twi_host_pkg::*;

   state_t st_reg, st_next;
   cmd_t cmd_reg, cmd_next;
   logic [3:0] cnt_reg, cnt_next;
   logic wait_reg, wait_next;
   logic poll_reg, poll_next;
   logic nack_reg, nack_next;
   logic done_reg, done_next;
   logic rdv_reg, rdv_next;
   logic [7:0] rdd_reg, rdd_next;
   logic wp_reg;
   logic eng_req, eng_done, eng_acked, eng_ackn, last;
   eng_op_t eng_op;
   logic [7:0] eng_byte, eng_rx;
   logic [7:0] dev_word;

   assign last = (cnt_reg == cmd_reg.len);
   // device type, select bits, page bit
   assign dev_word = {`DEV_TYPE, cmd_reg.dev_sel, cmd_reg.addr[`PAGE_BIT], 1'b0};

   always_comb begin
      eng_op = E_STOP;
      eng_byte = 8'h00;
      eng_ackn = 1'b1;
      unique case (st_reg)
         S_START, S_RSTART, S_PSTART: eng_op = E_START;
         S_DEV: begin
            eng_op = E_WRITE;
            eng_byte = dev_word | {7'h00, cmd_reg.op == OP_READ_CUR};
         end
         S_DEVR: begin
            eng_op = E_WRITE;
            eng_byte = dev_word | 8'h01;
         end
         S_PDEV: begin
            eng_op = E_WRITE;
            eng_byte = dev_word;
         end
         S_ADDR: begin
            eng_op = E_WRITE;
            eng_byte = cmd_reg.addr[7:0];
         end
         S_WDATA: begin
            eng_op = E_WRITE;
            eng_byte = wr_data_i;
         end
         // acknowledge all but the last byte
         S_RDATA: begin
            eng_op = E_READ;
            eng_ackn = last;
         end
         default: eng_op = E_STOP;
      endcase
   end

   assign eng_req = !wait_reg && (st_reg != S_IDLE) && (st_reg != S_WDATA || wr_valid_i);
   assign wr_ready_o = (st_reg == S_WDATA) && !wait_reg;
   assign cmd_ready_o = (st_reg == S_IDLE);

   always_comb begin
      st_next = st_reg;
      cmd_next = cmd_reg;
      cnt_next = cnt_reg;
      wait_next = wait_reg;
      poll_next = poll_reg;
      nack_next = nack_reg;
      done_next = 1'b0;
      rdv_next = 1'b0;
      rdd_next = rdd_reg;
      if (eng_req) begin
         wait_next = 1'b1;
      end
      if (st_reg == S_IDLE && cmd_valid_i) begin
         cmd_next = cmd_i;
         cnt_next = 4'h0;
         nack_next = 1'b0;
         poll_next = 1'b0;
         st_next = S_START;
      end else if (eng_done) begin
         wait_next = 1'b0;
         unique case (st_reg)
            S_START: st_next = S_DEV;
            S_DEV: begin
               if (!eng_acked) begin
                  nack_next = 1'b1;
                  st_next = S_STOP;
               end else begin
                  st_next = (cmd_reg.op == OP_READ_CUR) ? S_RDATA : S_ADDR;
               end
            end
            S_ADDR: begin
               if (!eng_acked) begin
                  nack_next = 1'b1;
                  st_next = S_STOP;
               end else begin
                  st_next = (cmd_reg.op == OP_READ_RAND) ? S_RSTART : S_WDATA;
               end
            end
            S_WDATA: begin
               cnt_next = cnt_reg + 4'h1;
               if (!eng_acked) begin
                  nack_next = 1'b1;
                  st_next = S_STOP;
               end else if (last) begin
                  poll_next = 1'b1;
                  st_next = S_STOP;
               end
            end
            S_RSTART: st_next = S_DEVR;
            S_DEVR: begin
               if (!eng_acked) begin
                  nack_next = 1'b1;
                  st_next = S_STOP;
               end else begin
                  st_next = S_RDATA;
               end
            end
            // nack then stop on last byte
            S_RDATA: begin
               rdv_next = 1'b1;
               rdd_next = eng_rx;
               cnt_next = cnt_reg + 4'h1;
               if (last) begin
                  st_next = S_STOP;
               end
            end
            S_STOP: begin
               if (poll_reg) begin
                  st_next = S_PSTART;
               end else begin
                  done_next = 1'b1;
                  st_next = S_IDLE;
               end
            end
            S_PSTART: st_next = S_PDEV;
            // poll until the device address word is acked
            S_PDEV: begin
               poll_next = !eng_acked;
               st_next = S_PSTOP;
            end
            S_PSTOP: begin
               if (poll_reg) begin
                  st_next = S_PSTART;
               end else begin
                  done_next = 1'b1;
                  st_next = S_IDLE;
               end
            end
            default: st_next = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= S_IDLE;
         cmd_reg <= '0;
         cnt_reg <= 4'h0;
         wait_reg <= 1'b0;
         poll_reg <= 1'b0;
         nack_reg <= 1'b0;
         done_reg <= 1'b0;
         rdv_reg <= 1'b0;
         rdd_reg <= 8'h00;
         wp_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         cnt_reg <= cnt_next;
         wait_reg <= wait_next;
         poll_reg <= poll_next;
         nack_reg <= nack_next;
         done_reg <= done_next;
         rdv_reg <= rdv_next;
         rdd_reg <= rdd_next;
         wp_reg <= protect_i;
      end
   end

   assign rd_valid_o = rdv_reg;
   assign rd_data_o = rdd_reg;
   assign done_o = done_reg;
   assign nack_o = nack_reg;
   assign write_protect_o = wp_reg;

   twi_bit_engine #(.QTR(QTR)) u_engine (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .req_i(eng_req),
      .op_i(eng_op),
      .tx_i(eng_byte),
      .ack_n_i(eng_ackn),
      .done_o(eng_done),
      .acked_o(eng_acked),
      .rx_o(eng_rx),
      .scl_o(scl_o),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o)
   );

   property p_dev_type;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (eng_req && (st_reg == S_DEV || st_reg == S_DEVR || st_reg == S_PDEV)) |-> eng_byte[7:4] == `DEV_TYPE;
   endproperty
   a_dev_type: assert property (p_dev_type) else $error("address word lacks device type");

   property p_start_first;
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(st_reg == S_DEV) |-> $past(st_reg) == S_START;
   endproperty
   a_start_first: assert property (p_start_first) else $error("address word without start");

   property p_read_stop;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg == S_RDATA && eng_done && last) |=> (st_reg == S_STOP) && rd_valid_o;
   endproperty
   a_read_stop: assert property (p_read_stop) else $error("last read byte not followed by stop");

   property p_seq_ack;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (eng_req && st_reg == S_RDATA) |-> (eng_ackn == (cnt_reg == cmd_reg.len));
   endproperty
   a_seq_ack: assert property (p_seq_ack) else $error("wrong acknowledge on read byte");

   property p_write_end;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg == S_WDATA && eng_done && eng_acked && last) |=> (st_reg == S_STOP) && poll_reg;
   endproperty
   a_write_end: assert property (p_write_end) else $error("write not ended by stop and poll");

   property p_page_limit;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg == S_WDATA && eng_done) |=> (st_reg == S_WDATA) == ($past(cnt_reg) != $past(cmd_reg.len) && $past(eng_acked));
   endproperty
   a_page_limit: assert property (p_page_limit) else $error("page write length not honoured");

   property p_poll;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (st_reg == S_PDEV && eng_done && !eng_acked) |=> (st_reg == S_PSTOP && poll_reg) ##1 (st_reg == S_PSTOP)[*2];
   endproperty
   a_poll: assert property (p_poll) else $error("refused poll not retried");

   property p_random;
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(st_reg == S_RSTART) |-> $past(st_reg) == S_ADDR && cmd_reg.op == OP_READ_RAND;
   endproperty
   a_random: assert property (p_random) else $error("repeated start outside random read");
endmodule : twi_eeprom_host
`default_nettype wire

// file: eeprom_model.sv
// Behavioural two-wire serial memory standing at the far end of the host
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
   parameter int WR_NS = 20000
) (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic wp_i,
   input wire logic [1:0] sel_i,
   output logic sda_oe_o
);
   logic [7:0] mem [0:511];
   logic [8:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] out_reg;
   logic [8:0] wa_q [$];
   logic [7:0] wd_q [$];
   logic busy_reg;
   logic rd_reg;
   logic page_reg;
   logic mack_reg;
   int bitn;
   int ph;

   initial begin
      for (int i = 0; i < 512; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      cnt_reg = 9'h000;
      busy_reg = 1'b0;
      sda_oe_o = 1'b0;
      bitn = 0;
      ph = 0;
   end

   always @(negedge sda_i) begin
      if (scl_i === 1'b1 && !busy_reg) begin
         ph = 1;
         bitn = 0;
         sda_oe_o = 1'b0;
         wa_q.delete();
         wd_q.delete();
      end
   end

   always @(posedge sda_i) begin
      if (scl_i === 1'b1 && !busy_reg) begin
         if (ph == 3 && wa_q.size() > 0 && !wp_i) begin
            foreach (wa_q[k]) begin
               mem[wa_q[k]] = wd_q[k];
            end
            busy_reg = 1'b1;
         end
         ph = 0;
         sda_oe_o = 1'b0;
      end
   end

   always @(posedge busy_reg) begin
      #(WR_NS);
      busy_reg = 1'b0;
   end

   always @(posedge scl_i) begin
      if (ph != 0) begin
         bitn = bitn + 1;
         if (bitn <= 8) begin
            shift_reg = {shift_reg[6:0], sda_i};
         end else begin
            mack_reg = !sda_i;
         end
      end
   end

   // change on fall, pull low only
   always @(negedge scl_i) begin
      if (ph != 0 && bitn == 8) begin
         sda_oe_o = 1'b0;
         if (ph == 1) begin
            if (shift_reg[7:4] == 4'hA && shift_reg[3:2] == sel_i) begin
               rd_reg = shift_reg[0];
               page_reg = shift_reg[1];
               sda_oe_o = 1'b1;
            end else begin
               ph = 0;
            end
         end else if (ph == 2) begin
            cnt_reg = {page_reg, shift_reg};
            sda_oe_o = 1'b1;
         end else if (ph == 3) begin
            wa_q.push_back(cnt_reg);
            wd_q.push_back(shift_reg);
            cnt_reg = {cnt_reg[8:4], cnt_reg[3:0] + 4'h1};
            sda_oe_o = 1'b1;
         end
      end else if (ph != 0 && bitn == 9) begin
         sda_oe_o = 1'b0;
         bitn = 0;
         if (ph == 1) begin
            ph = rd_reg ? 4 : 2;
         end else if (ph == 2) begin
            ph = 3;
         end else if (ph == 4 && !mack_reg) begin
            ph = 0;
         end
         if (ph == 4) begin
            out_reg = mem[cnt_reg];
            cnt_reg = cnt_reg + 9'h001;
            sda_oe_o = !out_reg[7];
         end
      end else if (ph == 4 && bitn >= 1 && bitn <= 7) begin
         sda_oe_o = !out_reg[7 - bitn];
      end
   end
endmodule : eeprom_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the two-wire serial memory host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import twi_host_pkg::*;
   logic core_clk_i;
   logic rstn_i;
   logic cmd_valid_i;
   cmd_t cmd_i;
   logic cmd_ready_o;
   logic wr_valid_i;
   logic [7:0] wr_data_i;
   logic wr_ready_o;
   logic rd_valid_o;
   logic [7:0] rd_data_o;
   logic done_o;
   logic nack_o;
   logic protect_i;
   logic write_protect_o;
   logic scl_o;
   logic sda_line;
   logic sda_o;
   logic sda_oe_o;
   logic dev_oe;
   logic [7:0] wbuf [0:15];
   logic [7:0] rbuf [0:15];
   int wi;
   int ri;
   int nwr;
   int n_errors;
   int comparisons;

   twi_eeprom_host #(.QTR(16'h0004)) twi_eeprom_host_inst (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_ready_o(cmd_ready_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o), .nack_o(nack_o),
      .protect_i(protect_i), .write_protect_o(write_protect_o), .scl_o(scl_o), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o)
   );
   eeprom_model #(.WR_NS(20000)) eeprom_model_inst (
      .scl_i(scl_o), .sda_i(sda_line), .wp_i(write_protect_o), .sel_i(2'b10), .sda_oe_o(dev_oe)
   );

   // Open-drain line with pull-up
   assign sda_line = ~((sda_oe_o & ~sda_o) | dev_oe);

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   always @(negedge core_clk_i) begin
      wr_valid_i <= (wi < nwr);
      wr_data_i <= wbuf[wi % 16];
   end

   always @(posedge core_clk_i) begin
      if (wr_valid_i && wr_ready_o) begin
         wi <= wi + 1;
      end
      if (rd_valid_o) begin
         rbuf[ri % 16] <= rd_data_o;
         ri <= ri + 1;
      end
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [7:0] exp_at(input logic [8:0] a);
      if (a[8:4] == 5'h1F) begin
         return 8'hC0 + {4'h0, a[3:0] + 4'hB};
      end
      return a[7:0] ^ 8'h5A;
   endfunction : exp_at

   task automatic run_cmd(input op_t op, input logic [1:0] sel, input logic [8:0] addr, input logic [3:0] len);
      int t;
      @(negedge core_clk_i);
      wi = 0;
      ri = 0;
      nwr = (op == OP_WRITE) ? int'(len) + 1 : 0;
      cmd_i = '{op: op, dev_sel: sel, addr: addr, len: len};
      cmd_valid_i = 1'b1;
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      check({8'h00, cmd_ready_o}, 9'h000);
      t = 0;
      while (done_o !== 1'b1 && t < 40000) begin
         @(negedge core_clk_i);
         t++;
      end
      check({8'h00, done_o}, 9'h001);
      check({8'h00, cmd_ready_o}, 9'h001);
      check({8'h00, wr_ready_o}, 9'h000);
   endtask : run_cmd

   task automatic test_reset();
      check({8'h00, scl_o}, 9'h001);
      check({8'h00, sda_oe_o}, 9'h000);
      check({8'h00, sda_o}, 9'h000);
      check({8'h00, cmd_ready_o}, 9'h001);
      check({8'h00, write_protect_o}, 9'h001);
   endtask : test_reset

   task automatic test_page_write();
      for (int i = 0; i < 16; i++) begin
         wbuf[i] = 8'hC0 + 8'(i);
      end
      run_cmd(OP_WRITE, 2'b10, 9'h1F5, 4'hF);
      check({8'h00, nack_o}, 9'h000);
      check(9'(wi), 9'h010);
      check({8'h00, eeprom_model_inst.busy_reg}, 9'h000);
      for (int j = 0; j < 16; j++) begin
         check({1'b0, eeprom_model_inst.mem[9'h1F0 + 9'(j)]}, {1'b0, exp_at(9'h1F0 + 9'(j))});
      end
   endtask : test_page_write

   task automatic test_reads();
      run_cmd(OP_READ_RAND, 2'b10, 9'h1FE, 4'h3);
      check(9'(ri), 9'h004);
      for (int k = 0; k < 4; k++) begin
         check({1'b0, rbuf[k]}, {1'b0, exp_at(9'h1FE + 9'(k))});
      end
      run_cmd(OP_READ_CUR, 2'b10, 9'h000, 4'h1);
      check({1'b0, rbuf[0]}, {1'b0, exp_at(9'h002)});
      check({1'b0, rbuf[1]}, {1'b0, exp_at(9'h003)});
   endtask : test_reads

   task automatic test_mismatch();
      run_cmd(OP_READ_CUR, 2'b01, 9'h000, 4'h0);
      check({8'h00, nack_o}, 9'h001);
      check(9'(ri), 9'h000);
      check({8'h00, scl_o}, 9'h001);
   endtask : test_mismatch

   task automatic test_protect();
      @(negedge core_clk_i);
      protect_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      check({8'h00, write_protect_o}, 9'h001);
      wbuf[0] = 8'h33;
      run_cmd(OP_WRITE, 2'b10, 9'h010, 4'h0);
      check({1'b0, eeprom_model_inst.mem[9'h010]}, {1'b0, exp_at(9'h010)});
      check({8'h00, nack_o}, 9'h000);
      protect_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check({8'h00, write_protect_o}, 9'h000);
   endtask : test_protect

   task automatic test_byte_write();
      wbuf[0] = 8'h77;
      run_cmd(OP_WRITE, 2'b10, 9'h123, 4'h0);
      check({1'b0, eeprom_model_inst.mem[9'h123]}, 9'h077);
      run_cmd(OP_READ_CUR, 2'b10, 9'h100, 4'h0);
      check({8'h00, nack_o}, 9'h000);
      check({1'b0, rbuf[0]}, {1'b0, exp_at(9'h124)});
   endtask : test_byte_write

   task automatic end_sim();
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (60000) @(posedge core_clk_i);
      n_errors++;
      end_sim();
   end

   initial begin
      rstn_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i = '0;
      wr_valid_i = 1'b0;
      wr_data_i = 8'h00;
      protect_i = 1'b0;
      wi = 0;
      ri = 0;
      nwr = 0;
      n_errors = 0;
      comparisons = 0;
      repeat (4) @(negedge core_clk_i);
      test_reset();
      rstn_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      test_page_write();
      test_reads();
      test_mismatch();
      test_protect();
      test_byte_write();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
